// ===== pkg/core_defines.svh
// Constants of the instruction decoder: flags, resets, opcodes, lengths and cycle counts
`ifndef CORE_DEFINES_SVH
`define CORE_DEFINES_SVH

`define FLAG_ZERO_BIT 1
`define FLAG_CARRY_BIT 2
`define FLAG_BANK_BIT 4
`define FLAGS_RESET 8'h02
`define CORE_REG_RESET 8'h00
`define PC_RESET 16'h0000
`define FLAGS_REG_ADDR 8'hF7
`define FLASH_BLOCK_BITS 7

`define OP_SV_CALL 8'h00
`define OP_ADD_IMM 8'h01
`define OP_PUSH_ACC 8'h08
`define OP_HALT 8'h30
`define OP_CMP_IMM 8'h39
`define OP_IND_MOVE_INC 8'h3E
`define OP_NOP 8'h40
`define OP_MOV_X_IMM 8'h57
`define OP_MOV_A_REG 8'h5D
`define OP_MOV_REG_A 8'h60
`define OP_MOV_REG_XOFF 8'h63
`define OP_AND_FLAGS 8'h70

`define CYC_SV_CALL 5'h0F
`define CYC_ADD_IMM 5'h04
`define CYC_PUSH_ACC 5'h04
`define CYC_HALT 5'h09
`define CYC_CMP_IMM 5'h05
`define CYC_IND_MOVE_INC 5'h0A
`define CYC_NOP 5'h04
`define CYC_MOV_X_IMM 5'h04
`define CYC_MOV_A_REG 5'h06
`define CYC_MOV_REG_A 5'h05
`define CYC_MOV_REG_XOFF 5'h09
`define CYC_AND_FLAGS 5'h04

`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3

// Instruction cycle at which each step happens, counted from the opcode address cycle
`define STEP_OPCODE 5'h01
`define STEP_BYTE1 5'h02
`define STEP_BYTE2 5'h03
`define STEP_EXEC 5'h03
`define STEP_EXEC3 5'h04
`define STEP_RDATA1 5'h05
`define STEP_RDATA2 5'h07

`endif

// ===== pkg/core_pkg.sv
// Types shared by the instruction decoder and its sequencer
package core_pkg;

  typedef enum logic [3:0] {
    CLS_NOP = 4'b0000,
    CLS_SV_CALL = 4'b0001,
    CLS_HALT = 4'b0010,
    CLS_ADD_IMM = 4'b0011,
    CLS_PUSH = 4'b0100,
    CLS_CMP_IMM = 4'b0101,
    CLS_IND_MOVE = 4'b0110,
    CLS_MOV_X_IMM = 4'b0111,
    CLS_MOV_A_REG = 4'b1000,
    CLS_MOV_REG_A = 4'b1001,
    CLS_MOV_REG_XOFF = 4'b1010,
    CLS_AND_FLAGS = 4'b1011
  } op_class_t;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } core_state_t;

endpackage

// ===== pkg/op_decode_if.sv
// Opcode in, table entry out, between the sequencer and the decode table
`timescale 1ns/10ps
interface op_decode_if;
  logic [7:0] opcode;
  logic [1:0] length;
  logic [4:0] cycles;
  logic is_jump;
  core_pkg::op_class_t op_class;

  modport table_side (
    input opcode,
    output length,
    output cycles,
    output is_jump,
    output op_class
  );

  modport user (
    output opcode,
    input length,
    input cycles,
    input is_jump,
    input op_class
  );
endinterface

// ===== rtl/core_sequencer.sv
// Instruction fetch, decode and execute sequencer of the 8-bit core
// Functional notes
// - Program ROM, RAM and register space are separate, ROM on its own bus.
// - Program space holds supervisory ROM and flash in 128-byte blocks.
// - 16-bit program counter advances across its full width every instruction.
// - Non-jump instruction spanning a 128-byte page costs one extra cycle.
// - Register space is two banks of 256 bytes.
// - Bank-select flag set picks bank 1, cleared picks bank 0.
// - Opcode 01: add immediate to accumulator, 2 bytes, 4 cycles, carry and zero.
// - Opcode 39: compare immediate, 2 bytes, 5 cycles, zero equal, carry less.
// - Opcode 3E: indirect load with pointer post-increment, 2 bytes, 10 cycles.
// - Opcode 60: accumulator to register at direct address, 2 bytes, 5 cycles.
// - Opcode 63: immediate to register at index plus offset, 3 bytes, 9 cycles.
// - Opcode 70: AND immediate into flags, 2 bytes, 4 cycles.
// - Flags read at register address F7h in either bank only.
// - Flags reset to 02h: zero set, bank select clear.
`include "core_defines.svh"
`timescale 1ns/10ps
module core_sequencer (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic [15:0] rom_addr,
  output logic rom_rd,
  input wire logic [7:0] rom_data,
  output logic [7:0] ram_addr,
  output logic ram_rd,
  output logic ram_we,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  output logic [8:0] reg_addr,
  output logic reg_rd,
  output logic reg_we,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic supervisory_call,
  output logic halted,
  output logic [7:0] flags,
  output logic [7:0] acc
);

  op_decode_if dec ();

  op_decode_table u_table (
    .dec(dec)
  );

  core_pkg::core_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] op_q, op_d, b1_q, b1_d, b2_q, b2_d, tmp_q, tmp_d;
  logic [7:0] acc_q, acc_d, x_q, x_d, sp_q, sp_d, flags_q, flags_d;
  logic [15:0] rom_addr_q, rom_addr_d;
  logic rom_rd_q, rom_rd_d;
  logic [7:0] ram_addr_q, ram_addr_d, ram_wdata_q, ram_wdata_d;
  logic ram_rd_q, ram_rd_d, ram_we_q, ram_we_d;
  logic [8:0] reg_addr_q, reg_addr_d;
  logic [7:0] reg_wdata_q, reg_wdata_d;
  logic reg_rd_q, reg_rd_d, reg_we_q, reg_we_d;
  logic sv_call_q, sv_call_d, halted_q, halted_d;
  logic [15:0] last_byte;
  logic [4:0] total;
  logic [8:0] sum;

  // The opcode is decoded straight off the ROM bus in the cycle it arrives
  assign dec.opcode = (cnt_q == `STEP_OPCODE) ? rom_data : op_q;
  assign last_byte = pc_q + {14'h0000, dec.length} - 16'h0001;
  assign total = dec.cycles + {4'h0, !dec.is_jump &&
    (pc_q[15:`FLASH_BLOCK_BITS] != last_byte[15:`FLASH_BLOCK_BITS])};
  assign sum = {1'b0, acc_q} + {1'b0, b1_q};

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 5'h01;
    pc_d = pc_q;
    op_d = op_q;
    b1_d = b1_q;
    b2_d = b2_q;
    tmp_d = tmp_q;
    acc_d = acc_q;
    x_d = x_q;
    sp_d = sp_q;
    flags_d = flags_q;
    rom_addr_d = rom_addr_q;
    rom_rd_d = 1'b0;
    ram_addr_d = ram_addr_q;
    ram_wdata_d = ram_wdata_q;
    ram_rd_d = 1'b0;
    ram_we_d = 1'b0;
    reg_addr_d = reg_addr_q;
    reg_wdata_d = reg_wdata_q;
    reg_rd_d = 1'b0;
    reg_we_d = 1'b0;
    sv_call_d = 1'b0;
    halted_d = halted_q;
    unique case (state_q)
      core_pkg::ST_START: begin
        rom_addr_d = pc_q;
        rom_rd_d = 1'b1;
        cnt_d = 5'h00;
        state_d = core_pkg::ST_RUN;
      end
      core_pkg::ST_RUN: begin
        // First operand read goes out before the opcode is known, else the byte
        // lands a cycle too late for 4-cycle two-byte opcodes; one-byte ones drop it
        if (cnt_q == 5'h00) begin
          rom_addr_d = pc_q + 16'h0001;
          rom_rd_d = 1'b1;
        end
        if (cnt_q == `STEP_OPCODE) begin
          op_d = rom_data;
          if (dec.length == `LEN_THREE) begin
            rom_addr_d = pc_q + 16'h0002;
            rom_rd_d = 1'b1;
          end
        end
        if (cnt_q == `STEP_BYTE1 && dec.length != `LEN_ONE) begin
          b1_d = rom_data;
        end
        if (cnt_q == `STEP_BYTE2 && dec.length == `LEN_THREE) begin
          b2_d = rom_data;
        end
        if (cnt_q == `STEP_EXEC) begin
          unique case (dec.op_class)
            core_pkg::CLS_ADD_IMM: begin
              acc_d = sum[7:0];
              flags_d[`FLAG_CARRY_BIT] = sum[8];
              flags_d[`FLAG_ZERO_BIT] = (sum[7:0] == 8'h00);
            end
            core_pkg::CLS_CMP_IMM: begin
              flags_d[`FLAG_ZERO_BIT] = (acc_q == b1_q);
              flags_d[`FLAG_CARRY_BIT] = (acc_q < b1_q);
            end
            core_pkg::CLS_AND_FLAGS: flags_d = flags_q & b1_q;
            core_pkg::CLS_MOV_X_IMM: x_d = b1_q;
            core_pkg::CLS_PUSH: begin
              ram_addr_d = sp_q;
              ram_wdata_d = acc_q;
              ram_we_d = 1'b1;
              sp_d = sp_q + 8'h01; // Stack wraps from FFh to 00h
            end
            core_pkg::CLS_MOV_REG_A: begin
              reg_addr_d = {flags_q[`FLAG_BANK_BIT], b1_q};
              reg_wdata_d = acc_q;
              reg_we_d = 1'b1;
            end
            core_pkg::CLS_MOV_A_REG: begin
              if (b1_q == `FLAGS_REG_ADDR) begin
                acc_d = flags_q;
                flags_d[`FLAG_ZERO_BIT] = (flags_q == 8'h00);
              end else begin
                reg_addr_d = {flags_q[`FLAG_BANK_BIT], b1_q};
                reg_rd_d = 1'b1;
              end
            end
            core_pkg::CLS_IND_MOVE: begin
              ram_addr_d = b1_q;
              ram_rd_d = 1'b1;
            end
            default: begin
            end
          endcase
        end
        if (cnt_q == `STEP_EXEC3 && dec.op_class == core_pkg::CLS_MOV_REG_XOFF) begin
          reg_addr_d = {flags_q[`FLAG_BANK_BIT], x_q + b1_q};
          reg_wdata_d = b2_q;
          reg_we_d = 1'b1;
        end
        if (cnt_q == `STEP_RDATA1) begin
          if (dec.op_class == core_pkg::CLS_MOV_A_REG && b1_q != `FLAGS_REG_ADDR) begin
            acc_d = reg_rdata;
            flags_d[`FLAG_ZERO_BIT] = (reg_rdata == 8'h00);
          end
          if (dec.op_class == core_pkg::CLS_IND_MOVE) begin
            tmp_d = ram_rdata;
            ram_addr_d = ram_rdata;
            ram_rd_d = 1'b1;
          end
        end
        if (cnt_q == `STEP_RDATA2 && dec.op_class == core_pkg::CLS_IND_MOVE) begin
          acc_d = ram_rdata;
          flags_d[`FLAG_ZERO_BIT] = (ram_rdata == 8'h00);
          ram_addr_d = b1_q;
          ram_wdata_d = tmp_q + 8'h01;
          ram_we_d = 1'b1;
        end
        if (cnt_q == total - 5'h01) begin
          // Full-width increment keeps flash block edges invisible to code
          pc_d = pc_q + {14'h0000, dec.length};
          cnt_d = 5'h00;
          if (dec.op_class == core_pkg::CLS_HALT) begin
            halted_d = 1'b1;
            state_d = core_pkg::ST_HALT;
          end else begin
            sv_call_d = (dec.op_class == core_pkg::CLS_SV_CALL);
            rom_addr_d = pc_q + {14'h0000, dec.length};
            rom_rd_d = 1'b1;
          end
        end
      end
      core_pkg::ST_HALT: begin
        // Only reset leaves this state
        cnt_d = 5'h00;
      end
      default: begin
        state_d = core_pkg::ST_START;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= core_pkg::ST_START;
      cnt_q <= 5'h00;
      pc_q <= `PC_RESET;
      op_q <= `CORE_REG_RESET;
      b1_q <= `CORE_REG_RESET;
      b2_q <= `CORE_REG_RESET;
      tmp_q <= `CORE_REG_RESET;
      acc_q <= `CORE_REG_RESET;
      x_q <= `CORE_REG_RESET;
      sp_q <= `CORE_REG_RESET;
      flags_q <= `FLAGS_RESET;
      rom_addr_q <= `PC_RESET;
      rom_rd_q <= 1'b0;
      ram_addr_q <= 8'h00;
      ram_wdata_q <= 8'h00;
      ram_rd_q <= 1'b0;
      ram_we_q <= 1'b0;
      reg_addr_q <= 9'h000;
      reg_wdata_q <= 8'h00;
      reg_rd_q <= 1'b0;
      reg_we_q <= 1'b0;
      sv_call_q <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      op_q <= op_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      tmp_q <= tmp_d;
      acc_q <= acc_d;
      x_q <= x_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
      rom_addr_q <= rom_addr_d;
      rom_rd_q <= rom_rd_d;
      ram_addr_q <= ram_addr_d;
      ram_wdata_q <= ram_wdata_d;
      ram_rd_q <= ram_rd_d;
      ram_we_q <= ram_we_d;
      reg_addr_q <= reg_addr_d;
      reg_wdata_q <= reg_wdata_d;
      reg_rd_q <= reg_rd_d;
      reg_we_q <= reg_we_d;
      sv_call_q <= sv_call_d;
      halted_q <= halted_d;
    end
  end

  assign rom_addr = rom_addr_q;
  assign rom_rd = rom_rd_q;
  assign ram_addr = ram_addr_q;
  assign ram_rd = ram_rd_q;
  assign ram_we = ram_we_q;
  assign ram_wdata = ram_wdata_q;
  assign reg_addr = reg_addr_q;
  assign reg_rd = reg_rd_q;
  assign reg_we = reg_we_q;
  assign reg_wdata = reg_wdata_q;
  assign supervisory_call = sv_call_q;
  assign halted = halted_q;
  assign flags = flags_q;
  assign acc = acc_q;

endmodule // core_sequencer

// ===== rtl/op_decode_table.sv
// Opcode table: length in bytes, cycle count and execution class
`include "core_defines.svh"
`timescale 1ns/10ps
module op_decode_table (
  op_decode_if.table_side dec
);

  always_comb begin
    dec.is_jump = 1'b0;
    dec.length = `LEN_ONE;
    dec.cycles = `CYC_NOP;
    dec.op_class = core_pkg::CLS_NOP;
    unique case (dec.opcode)
      `OP_SV_CALL: begin
        dec.cycles = `CYC_SV_CALL;
        dec.op_class = core_pkg::CLS_SV_CALL;
      end
      `OP_HALT: begin
        dec.cycles = `CYC_HALT;
        dec.op_class = core_pkg::CLS_HALT;
      end
      `OP_NOP: begin
        dec.cycles = `CYC_NOP;
      end
      `OP_ADD_IMM: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_ADD_IMM;
        dec.op_class = core_pkg::CLS_ADD_IMM;
      end
      `OP_PUSH_ACC: begin
        dec.cycles = `CYC_PUSH_ACC;
        dec.op_class = core_pkg::CLS_PUSH;
      end
      `OP_CMP_IMM: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_CMP_IMM;
        dec.op_class = core_pkg::CLS_CMP_IMM;
      end
      `OP_IND_MOVE_INC: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_IND_MOVE_INC;
        dec.op_class = core_pkg::CLS_IND_MOVE;
      end
      `OP_MOV_X_IMM: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_MOV_X_IMM;
        dec.op_class = core_pkg::CLS_MOV_X_IMM;
      end
      `OP_MOV_A_REG: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_MOV_A_REG;
        dec.op_class = core_pkg::CLS_MOV_A_REG;
      end
      `OP_MOV_REG_A: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_MOV_REG_A;
        dec.op_class = core_pkg::CLS_MOV_REG_A;
      end
      `OP_MOV_REG_XOFF: begin
        dec.length = `LEN_THREE;
        dec.cycles = `CYC_MOV_REG_XOFF;
        dec.op_class = core_pkg::CLS_MOV_REG_XOFF;
      end
      `OP_AND_FLAGS: begin
        dec.length = `LEN_TWO;
        dec.cycles = `CYC_AND_FLAGS;
        dec.op_class = core_pkg::CLS_AND_FLAGS;
      end
      default: begin
        // Opcodes outside this subset run as one-byte no-operations
        dec.op_class = core_pkg::CLS_NOP;
      end
    endcase
  end

endmodule // op_decode_table

// ===== tb/cpu_address_space_and_opcode_timing_tb.sv
// Self-checking bench running a short program through the core sequencer
`timescale 1ns/10ps
module cpu_address_space_and_opcode_timing_tb;
  logic sys_clk, rst_n, rom_rd, ram_rd, ram_we, reg_rd, reg_we, supervisory_call, halted;
  logic [15:0] rom_addr;
  logic [7:0] rom_data, ram_addr, ram_wdata, ram_rdata, reg_wdata, reg_rdata, flags, acc;
  logic [8:0] reg_addr;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int sv_cnt = 0;
  int sv_cyc = 0;
  int fetch_cyc [0:255];
  logic [7:0] acc_at [0:255];
  logic [7:0] flg_at [0:255];
  logic rd_prev = 1'b0;

  core_sequencer uut (.sys_clk(sys_clk), .rst_n(rst_n), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supervisory_call(supervisory_call), .halted(halted), .flags(flags), .acc(acc));
  mem_partner mem (.sys_clk(sys_clk), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;
  // A rising read strobe is an opcode fetch, operand reads follow it back to back;
  // state seen there is the prior result
  always @(negedge sys_clk) begin
    if (rom_rd === 1'b1 && rd_prev !== 1'b1 && fetch_cyc[rom_addr[7:0]] == 0) begin
      fetch_cyc[rom_addr[7:0]] = cyc;
      acc_at[rom_addr[7:0]] = acc;
      flg_at[rom_addr[7:0]] = flags;
    end
    if (supervisory_call === 1'b1) begin
      sv_cnt++;
      sv_cyc = cyc;
    end
    rd_prev = rom_rd;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bank select is never set, so everything stays in bank 0
  task automatic load_prog;
    logic [7:0] p [0:23];
    p = '{8'h40, 8'h01, 8'h05, 8'h39, 8'h05, 8'h39, 8'h06, 8'h08, 8'h01, 8'hFB, 8'h70, 8'hFD,
      8'h3E, 8'h20, 8'h60, 8'h11, 8'h57, 8'h10, 8'h63, 8'h05, 8'hAA, 8'h5D, 8'hF7, 8'h00};
    for (int i = 0; i < 256; i++) begin
      mem.rom_mem[i] = (i < 24) ? p[i] : 8'h40;
      fetch_cyc[i] = 0;
    end
    mem.rom_mem[8'h7F] = 8'h01;
    mem.rom_mem[8'h80] = 8'h01;
    mem.rom_mem[8'h81] = 8'h30;
    // Register read over the bus, of the byte written by the direct store
    mem.rom_mem[8'h18] = 8'h5D;
    mem.rom_mem[8'h19] = 8'h11;
    mem.ram_mem[8'h20] = 8'h30;
    mem.ram_mem[8'h30] = 8'h5A;
  endtask

  task automatic run_to_halt;
    int n;
    n = 0;
    rst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    while (halted !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0000, halted}, 16'h0001);
    if (n >= 2000) test_done();
    repeat (20) @(negedge sys_clk);
    $display("program run done");
  endtask

  task automatic test_timing;
    logic [7:0] ta [0:14];
    logic [7:0] tn [0:14];
    logic [7:0] tc [0:14];
    ta = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12,
      8'h15, 8'h17, 8'h7E, 8'h7F};
    tn = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h15,
      8'h17, 8'h18, 8'h7F, 8'h81};
    tc = '{8'h04, 8'h04, 8'h05, 8'h05, 8'h04, 8'h04, 8'h04, 8'h0A, 8'h05, 8'h04, 8'h09,
      8'h06, 8'h0F, 8'h04, 8'h05};
    for (int i = 0; i < 15; i++) begin
      chk(16'(fetch_cyc[tn[i]] - fetch_cyc[ta[i]]), {8'h00, tc[i]});
    end
    chk(16'(fetch_cyc[8'h1A] - fetch_cyc[8'h18]), 16'h0006);
    chk(16'(fetch_cyc[8'h82]), 16'h0000);
    $display("timing test done");
  endtask

  task automatic test_alu;
    logic [7:0] ta [0:8];
    logic [7:0] tv [0:8];
    logic [7:0] tf [0:8];
    ta = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h81};
    tv = '{8'h00, 8'h05, 8'h05, 8'h05, 8'h05, 8'h00, 8'h00, 8'h5A, 8'h5B};
    tf = '{8'h02, 8'h00, 8'h02, 8'h04, 8'h04, 8'h06, 8'h04, 8'h04, 8'h00};
    for (int i = 0; i < 9; i++) begin
      chk({acc_at[ta[i]], flg_at[ta[i]]}, {tv[i], tf[i]});
    end
    chk({acc_at[8'h17], flg_at[8'h17]}, 16'h0404);
    chk({acc_at[8'h1A], flg_at[8'h1A]}, 16'h5A04);
    $display("accumulator and flags test done");
  endtask

  task automatic test_side;
    chk({8'h00, mem.ram_mem[8'h00]}, 16'h0005);
    chk({8'h00, mem.ram_mem[8'h20]}, 16'h0031);
    chk({8'h00, mem.reg_mem[9'h011]}, 16'h005A);
    chk({8'h00, mem.reg_mem[9'h015]}, 16'h00AA);
    chk(16'(sv_cnt), 16'h0001);
    chk(16'(sv_cyc), 16'(fetch_cyc[8'h18]));
    $display("memory side effects test done");
  endtask

  initial begin
    rst_n = 1'b0;
    load_prog();
    run_to_halt();
    test_timing();
    test_alu();
    test_side();
    test_done();
  end
endmodule // cpu_address_space_and_opcode_timing_tb

// ===== tb/mem_partner.sv
// Program ROM, data RAM and two-bank register space answering the core
`timescale 1ns/10ps
module mem_partner (
  input logic sys_clk,
  input logic [15:0] rom_addr,
  input logic rom_rd,
  output logic [7:0] rom_data,
  input logic [7:0] ram_addr,
  input logic ram_rd,
  input logic ram_we,
  input logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  input logic [8:0] reg_addr,
  input logic reg_rd,
  input logic reg_we,
  input logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata
);
  logic [7:0] rom_mem [0:255];
  logic [7:0] ram_mem [0:255];
  logic [7:0] reg_mem [0:511];
  initial begin
    rom_data = 8'h00;
    ram_rdata = 8'h00;
    reg_rdata = 8'h00;
  end
  // Idle buses toggle, so a sample one cycle late sees the last byte inverted
  always @(posedge sys_clk) begin
    rom_data <= rom_rd ? rom_mem[rom_addr[7:0]] : ~rom_data;
    ram_rdata <= ram_rd ? ram_mem[ram_addr] : ~ram_rdata;
    reg_rdata <= reg_rd ? reg_mem[reg_addr] : ~reg_rdata;
    if (ram_we) begin
      ram_mem[ram_addr] <= ram_wdata;
    end
    if (reg_we) begin
      reg_mem[reg_addr] <= reg_wdata;
    end
  end
endmodule // mem_partner

// ===== tb/seq_checker.sv
// Port assertions for the core sequencer
`include "core_defines.svh"
`timescale 1ns/10ps
module seq_checker (
  input logic sys_clk,
  input logic rst_n,
  input logic [15:0] rom_addr,
  input logic rom_rd,
  input logic ram_rd,
  input logic ram_we,
  input logic [8:0] reg_addr,
  input logic reg_rd,
  input logic reg_we,
  input logic supervisory_call,
  input logic halted,
  input logic [7:0] flags,
  input logic [7:0] acc
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_values: assert property (
    !$past(rst_n) |-> flags == `FLAGS_RESET && acc == 8'h00 && !rom_rd)
    else $error("reset values wrong");
  a_operand_next_byte: assert property (
    rom_rd && $past(rom_rd) |-> rom_addr == $past(rom_addr) + 16'h0001)
    else $error("operand address not consecutive");
  a_halt_no_fetch: assert property (halted |-> !rom_rd)
    else $error("fetch while halted");
  a_halt_sticky: assert property (halted |=> halted)
    else $error("halt left without reset");
  a_halt_frozen: assert property (halted |=> $stable(flags) && $stable(acc))
    else $error("state changed while halted");
  a_bank_select: assert property (
    (reg_we || reg_rd) |-> reg_addr[8] == flags[`FLAG_BANK_BIT])
    else $error("register bank differs from flag");
  a_call_pulse: assert property (supervisory_call |-> rom_rd ##1 !supervisory_call)
    else $error("call pulse malformed");
  a_ram_rd_pulse: assert property (ram_rd |=> !ram_rd && !ram_we)
    else $error("ram read strobe too long");
  a_reg_we_pulse: assert property (reg_we |=> !reg_we)
    else $error("register write strobe too long");

  c_call: cover property (supervisory_call);
  c_reg_write: cover property (reg_we);
  c_ram_write: cover property (ram_we);
  c_halt: cover property ($rose(halted));
endmodule // seq_checker

bind core_sequencer seq_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .rom_addr(rom_addr),
  .rom_rd(rom_rd), .ram_rd(ram_rd), .ram_we(ram_we), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_we(reg_we), .supervisory_call(supervisory_call), .halted(halted), .flags(flags),
  .acc(acc));
